// [pkg/ebisg_map.svh]
/*
 Register offsets, field positions, reset values and strobe codes
 of the speculation guard and 16-bit port sizer.
 Assumes it is included by its bare name from the design top and bench.
*/
`ifndef EBISG_MAP_SVH
`define EBISG_MAP_SVH

`define EBISG_GUARD_BASE_OFS 32'h8007FC24
`define EBISG_GUARD_MASK_OFS 32'h8007FC28
`define EBISG_IRQ_STATUS_OFS 32'h8007FC2C
`define EBISG_IRQ_MASK_OFS 32'h8007FC30
`define EBISG_STATE_OFS 32'h8007FC34

`define EBISG_GUARD_BASE_RST 32'h00000000
`define EBISG_GUARD_MASK_RST 32'h00000000
`define EBISG_IRQ_MASK_RST 2'h0

`define EBISG_BASE_HI 31
`define EBISG_BASE_LO 10
`define EBISG_MASK_HI 15
`define EBISG_MASK_LO 10
`define EBISG_UPPER_LO 16

`define EBISG_EV_HOLD 0
`define EBISG_EV_ERR 1
`define EBISG_EV_W 2

`define EBISG_STB_BYTE0 4'h5
`define EBISG_STB_BYTE1 4'h9
`define EBISG_STB_BYTE2 4'h7
`define EBISG_STB_BYTE3 4'hB
`define EBISG_STB_HALF0 4'h1
`define EBISG_STB_HALF2 4'h3
`define EBISG_STB_WORD0 4'h0
`define EBISG_STB_WORD1 4'h2
`define EBISG_STB_NONE 4'hF

`endif

// [pkg/ebisg_pkg.sv]
/*
 Types of the speculation guard and 16-bit port sizer.
 Assumes ebisg_map.svh sits on the include path.
*/
package ebisg_pkg;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_HOLD = 6'h02,
      ST_ISSUE = 6'h04,
      ST_WAIT = 6'h08,
      ST_REL = 6'h10,
      ST_DONE = 6'h20
   } ebisg_state_t;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0,
      SZ_HALF = 2'h1,
      SZ_WORD = 2'h2
   } ebisg_size_t;

   typedef struct packed {
      ebisg_state_t state;
      logic [31:0] addr;
      ebisg_size_t size;
      logic write;
      logic [31:0] wdata;
      logic port16;
      logic beat;
      logic err;
      logic [31:0] rdata;
      logic [31:0] base;
      logic [31:0] mask;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic [31:0] prdata;
      logic pslverr;
      logic [2:0] ta_sync;
      logic [2:0] tea_sync;
      logic ta_n;
      logic tea_n;
      logic [31:0] d1;
      logic [31:0] d2;
      logic [31:0] d3;
      logic ext_start;
      logic [31:0] ext_addr;
      logic [31:0] ext_wdata;
      logic ext_data_oe_n;
      logic [3:0] strobes;
      logic core_ack;
      logic core_err;
      logic beat_done;
      logic beat_err;
   } ebisg_regs_t;

endpackage : ebisg_pkg

// [rtl/ebisg_top.sv]
/*
 Speculation guard and 16-bit port sizer of the external bus unit,
 with an APB register slave and a level interrupt.
 Assumes one 100 MHz clock for core bus, APB and external bus; the
 chip-select unit supplies the port width of each access.
*/
`timescale 1ns/100ps
`include "ebisg_map.svh"

module ebisg_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic core_req,
   input wire logic [31:0] core_addr,
   input wire logic [1:0] core_size,
   input wire logic core_write,
   input wire logic [31:0] core_wdata,
   input wire logic core_spec,
   input wire logic cs_port16,
   output logic core_ack,
   output logic core_err,
   output logic [31:0] core_rdata,
   output logic core_beat_done,
   output logic core_beat_err,
   output logic core_spec_blocked,
   output logic ext_start,
   output logic [31:0] ext_addr,
   output logic [31:0] ext_wdata,
   output logic ext_data_oe_n,
   input wire logic [31:0] ext_rdata,
   output logic [0:3] byte_lane_strobes,
   input wire logic ext_ta_n,
   input wire logic transfer_error_ack_n,
   output logic irq
);

   ebisg_pkg::ebisg_regs_t s;
   ebisg_pkg::ebisg_regs_t next_s;

   // Mask ones widen the match, so one base covers 1 to 64 Kbytes
   function automatic logic guard_hit(
      input logic [31:0] a,
      input logic [31:0] base,
      input logic [31:0] mask
   );
      logic [21:0] same;
      logic [5:0] low;
      same = ~(a[`EBISG_BASE_HI:`EBISG_BASE_LO] ^
               base[`EBISG_BASE_HI:`EBISG_BASE_LO]);
      low = same[5:0] | mask[`EBISG_MASK_HI:`EBISG_MASK_LO];
      return (&low) & (&same[21:6]);
   endfunction : guard_hit

   // Active-low strobes for one beat of a 16-bit port access
   function automatic logic [3:0] strobe16(
      input ebisg_pkg::ebisg_size_t sz,
      input logic [1:0] off,
      input logic beat
   );
      logic [3:0] r;
      r = `EBISG_STB_NONE;
      case (sz)
         ebisg_pkg::SZ_BYTE: begin
            case (off)
               2'h0: r = `EBISG_STB_BYTE0;
               2'h1: r = `EBISG_STB_BYTE1;
               2'h2: r = `EBISG_STB_BYTE2;
               default: r = `EBISG_STB_BYTE3;
            endcase
         end
         ebisg_pkg::SZ_HALF: begin
            r = off[1] ? `EBISG_STB_HALF2 : `EBISG_STB_HALF0;
         end
         ebisg_pkg::SZ_WORD: begin
            // Strobe three stays low on both beats
            r = beat ? `EBISG_STB_WORD1 : `EBISG_STB_WORD0;
         end
         default: r = `EBISG_STB_NONE;
      endcase
      return r;
   endfunction : strobe16

   // Active-low strobes for a full 32-bit port
   function automatic logic [3:0] strobe32(
      input ebisg_pkg::ebisg_size_t sz,
      input logic [1:0] off
   );
      logic [3:0] r;
      r = `EBISG_STB_NONE;
      case (sz)
         ebisg_pkg::SZ_BYTE: r = ~(4'h8 >> off);
         ebisg_pkg::SZ_HALF: r = off[1] ? 4'hC : 4'h3;
         ebisg_pkg::SZ_WORD: r = 4'h0;
         default: r = `EBISG_STB_NONE;
      endcase
      return r;
   endfunction : strobe32

   logic hit_now;
   logic setup;
   logic access;
   logic [31:0] rd_mux;
   logic dec_ok;
   logic [`EBISG_EV_W-1:0] ev;
   logic half_sel;
   logic last_beat;

   assign hit_now = guard_hit(core_addr, s.base, s.mask);
   assign setup = psel & ~penable;
   assign access = psel & penable;

   always_comb begin
      rd_mux = 32'h00000000;
      dec_ok = 1'b1;
      case (paddr)
         `EBISG_GUARD_BASE_OFS: rd_mux = s.base;
         `EBISG_GUARD_MASK_OFS: rd_mux = s.mask;
         `EBISG_IRQ_STATUS_OFS: rd_mux = {30'h00000000, s.irq_status};
         `EBISG_IRQ_MASK_OFS: rd_mux = {30'h00000000, s.irq_mask};
         `EBISG_STATE_OFS: rd_mux = {26'h0000000, s.state};
         default: dec_ok = 1'b0;
      endcase
   end

   always_comb begin
      next_s = s;
      ev = '0;
      half_sel = (s.size == ebisg_pkg::SZ_WORD) ? s.beat : s.addr[1];
      last_beat = ~(s.port16 & (s.size == ebisg_pkg::SZ_WORD)) | s.beat;
      next_s.ext_start = 1'b0;
      next_s.core_ack = 1'b0;
      next_s.core_err = 1'b0;
      next_s.beat_done = 1'b0;
      next_s.beat_err = 1'b0;

      // Pin inputs: a change counts once stages two and three agree
      next_s.ta_sync = {s.ta_sync[1:0], ext_ta_n};
      next_s.tea_sync = {s.tea_sync[1:0], transfer_error_ack_n};
      if (s.ta_sync[1] == s.ta_sync[2]) begin
         next_s.ta_n = s.ta_sync[2];
      end
      if (s.tea_sync[1] == s.tea_sync[2]) begin
         next_s.tea_n = s.tea_sync[2];
      end
      // Data takes as many stages as the acknowledges it pairs with
      next_s.d1 = ext_rdata;
      next_s.d2 = s.d1;
      next_s.d3 = s.d2;

      // APB: data latched in setup, answered in the first access cycle
      if (setup) begin
         next_s.prdata = rd_mux;
         next_s.pslverr = ~dec_ok;
      end
      if (access & pwrite & dec_ok) begin
         case (paddr)
            `EBISG_GUARD_BASE_OFS: begin
               next_s.base = {pwdata[`EBISG_BASE_HI:`EBISG_BASE_LO],
                              10'h000};
            end
            `EBISG_GUARD_MASK_OFS: begin
               next_s.mask = {16'h0000,
                              pwdata[`EBISG_MASK_HI:`EBISG_MASK_LO],
                              10'h000};
            end
            `EBISG_IRQ_MASK_OFS: next_s.irq_mask = pwdata[1:0];
            default: next_s.mask = s.mask;
         endcase
      end
      if (access & ~pwrite & (paddr == `EBISG_IRQ_STATUS_OFS)) begin
         next_s.irq_status = '0;
      end

      case (s.state)
         ebisg_pkg::ST_IDLE: begin
            // The held request is still up in the ack cycle
            if (core_req & ~s.core_ack) begin
               next_s.addr = core_addr;
               next_s.size = ebisg_pkg::ebisg_size_t'(core_size);
               next_s.write = core_write;
               next_s.wdata = core_wdata;
               next_s.port16 = cs_port16;
               next_s.beat = 1'b0;
               next_s.err = 1'b0;
               next_s.rdata = 32'h00000000;
               // Stores are never speculative, so only loads are held
               if (core_spec & ~core_write & hit_now) begin
                  next_s.state = ebisg_pkg::ST_HOLD;
                  ev[`EBISG_EV_HOLD] = 1'b1;
               end else begin
                  next_s.state = ebisg_pkg::ST_ISSUE;
               end
            end
         end
         ebisg_pkg::ST_HOLD: begin
            if (~core_req) begin
               // A discarded speculative load never reaches the pins
               next_s.state = ebisg_pkg::ST_IDLE;
            end else if (~core_spec) begin
               next_s.state = ebisg_pkg::ST_ISSUE;
            end
         end
         ebisg_pkg::ST_ISSUE: begin
            next_s.ext_start = 1'b1;
            next_s.ext_data_oe_n = ~s.write;
            if (s.port16) begin
               next_s.strobes = strobe16(s.size, s.addr[1:0], s.beat);
               // Address bit 30 rides out on strobe two
               next_s.ext_addr = {s.addr[31:2], half_sel, 1'b0};
               // Small port uses the upper half of the bus only
               next_s.ext_wdata = {half_sel ? s.wdata[15:0] :
                                   s.wdata[31:16], 16'h0000};
            end else begin
               next_s.strobes = strobe32(s.size, s.addr[1:0]);
               next_s.ext_addr = s.addr;
               next_s.ext_wdata = s.wdata;
            end
            next_s.state = ebisg_pkg::ST_WAIT;
         end
         ebisg_pkg::ST_WAIT: begin
            // Error overrides acknowledge and ends the beat
            if (~s.tea_n | ~s.ta_n) begin
               next_s.err = s.err | ~s.tea_n;
               next_s.beat_done = 1'b1;
               next_s.beat_err = s.err | ~s.tea_n;
               if (~s.write) begin
                  if (s.port16 & half_sel) begin
                     next_s.rdata[15:0] = s.d3[31:16];
                  end else if (s.port16) begin
                     next_s.rdata[31:16] = s.d3[31:16];
                  end else begin
                     next_s.rdata = s.d3;
                  end
               end
               next_s.state = ebisg_pkg::ST_REL;
            end
         end
         ebisg_pkg::ST_REL: begin
            next_s.ext_data_oe_n = 1'b1;
            if (s.ta_n & s.tea_n) begin
               if (last_beat) begin
                  next_s.state = ebisg_pkg::ST_DONE;
               end else begin
                  next_s.beat = 1'b1;
                  next_s.state = ebisg_pkg::ST_ISSUE;
               end
            end
         end
         ebisg_pkg::ST_DONE: begin
            next_s.core_ack = 1'b1;
            next_s.core_err = s.err;
            next_s.strobes = `EBISG_STB_NONE;
            ev[`EBISG_EV_ERR] = s.err;
            next_s.state = ebisg_pkg::ST_IDLE;
         end
         default: next_s.state = ebisg_pkg::ST_IDLE;
      endcase

      // Set after clear: an event in the read cycle is kept
      next_s.irq_status = next_s.irq_status | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.state <= ebisg_pkg::ST_IDLE;
         s.base <= `EBISG_GUARD_BASE_RST;
         s.mask <= `EBISG_GUARD_MASK_RST;
         s.irq_mask <= `EBISG_IRQ_MASK_RST;
         s.ta_sync <= 3'h7;
         s.tea_sync <= 3'h7;
         s.ta_n <= 1'b1;
         s.tea_n <= 1'b1;
         s.ext_data_oe_n <= 1'b1;
         s.strobes <= `EBISG_STB_NONE;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = access;
   assign pslverr = access & s.pslverr;
   assign core_ack = s.core_ack;
   assign core_err = s.core_err;
   assign core_rdata = s.rdata;
   assign core_beat_done = s.beat_done;
   assign core_beat_err = s.beat_err;
   assign core_spec_blocked = (s.state == ebisg_pkg::ST_HOLD);
   assign ext_start = s.ext_start;
   assign ext_addr = s.ext_addr;
   assign ext_wdata = s.ext_wdata;
   assign ext_data_oe_n = s.ext_data_oe_n;
   assign byte_lane_strobes = s.strobes;
   assign irq = |(s.irq_status & s.irq_mask);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   spec_hold_entry_a: assert property (
      (s.state == ebisg_pkg::ST_IDLE) && core_req && !s.core_ack &&
      core_spec && !core_write && hit_now
      |=> core_spec_blocked && !ext_start)
      else $error("guarded speculative load not held");
   upper_match_a: assert property (
      hit_now |-> core_addr[31:16] == s.base[31:16])
      else $error("guard hit with upper address mismatch");
   mask_widen_a: assert property (
      (s.mask[15:10] == 6'h3F) && (core_addr[31:16] == s.base[31:16])
      |-> hit_now)
      else $error("full mask did not cover 64 Kbyte block");
   hold_wait_a: assert property (
      core_spec_blocked && core_req && core_spec
      |=> core_spec_blocked && !ext_start)
      else $error("blocked load issued while still speculative");
   reserved_zero_a: assert property (
      s.base[9:0] == 10'h000 && s.mask[31:16] == 16'h0000 &&
      s.mask[9:0] == 10'h000)
      else $error("reserved guard bits not zero");
   word_strobe3_a: assert property (
      ext_start && s.port16
      |-> byte_lane_strobes[3] == (s.size != ebisg_pkg::SZ_WORD))
      else $error("strobe three wrong for operand size");
   addr30_pin_a: assert property (
      ext_start && s.port16 |-> byte_lane_strobes[2] == ext_addr[1])
      else $error("strobe two does not follow address bit 30");
   second_beat_a: assert property (
      ext_start && s.port16 && (s.size == ebisg_pkg::SZ_WORD) && !s.beat
      |-> byte_lane_strobes == 4'h0
          ##[1:1000] ext_start && byte_lane_strobes == 4'h2)
      else $error("word to small port lacks second beat");
   err_carry_a: assert property (
      s.err && (s.state == ebisg_pkg::ST_WAIT) && !s.ta_n
      |=> core_beat_done && core_beat_err)
      else $error("later beat not flagged after error");
   hold_event_a: assert property (
      $rose(core_spec_blocked) |-> s.irq_status[`EBISG_EV_HOLD])
      else $error("hold event not recorded in status");

   hold_seen_c: cover property (core_spec_blocked ##1 !core_spec_blocked);
   word16_c: cover property (
      core_ack && s.port16 && (s.size == ebisg_pkg::SZ_WORD));
   err_word_c: cover property (core_ack && core_err && s.port16);
   irq_c: cover property (irq);

endmodule : ebisg_top

// [tb/ebisg_slave.sv]
/*
 External 16-bit port model: a small half-word memory on the upper
 data half, prompt or slow, with an error on command.
 Assumes the design's beat handshake on the shared clock.
*/
`timescale 1ns/100ps

module ebisg_slave (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ext_start,
   input wire logic [31:0] ext_addr,
   input wire logic [31:0] ext_wdata,
   input wire logic ext_data_oe_n,
   input wire logic [0:3] byte_lane_strobes,
   input wire logic [3:0] lag,
   input wire logic fail_next,
   output logic [31:0] ext_rdata,
   output logic ext_ta_n,
   output logic transfer_error_ack_n
);
   logic [15:0] mem [256];
   logic [15:0] junk;
   logic [7:0] idx;
   logic [3:0] cnt;
   logic busy, err, ack;

   // Released lanes toggle, so stale data can never pass for an answer
   assign ack = !(ext_ta_n && transfer_error_ack_n);
   assign ext_rdata = {ack ? mem[idx] : junk, ~junk};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_ta_n <= 1'b1;
         transfer_error_ack_n <= 1'b1;
         busy <= 1'b0;
         junk <= 16'h5A5A;
      end else begin
         junk <= ~junk;
         if (ext_start) begin
            busy <= 1'b1;
            cnt <= 4'h0;
            idx <= ext_addr[8:1];
            err <= fail_next && !ext_addr[1];
            if (!ext_data_oe_n && !byte_lane_strobes[0])
               mem[ext_addr[8:1]][15:8] <= ext_wdata[31:24];
            if (!ext_data_oe_n && !byte_lane_strobes[1])
               mem[ext_addr[8:1]][7:0] <= ext_wdata[23:16];
         end else if (busy) begin
            cnt <= cnt + 4'h1;
            if (cnt == lag && err)
               transfer_error_ack_n <= 1'b0;
            else if (cnt == lag)
               ext_ta_n <= 1'b0;
            // Held six cycles: the design needs four to see it
            if (cnt == lag + 4'h6) begin
               ext_ta_n <= 1'b1;
               transfer_error_ack_n <= 1'b1;
               busy <= 1'b0;
            end
         end
      end
   end
endmodule : ebisg_slave

// [tb/tb.sv]
/*
 Self-checking bench: APB registers, speculation guard, 16-bit port
 sizing, error beats and the interrupt.
 Assumes the design top and ebisg_slave on the compile list.
*/
`timescale 1ns/100ps
`include "ebisg_map.svh"

module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, core_addr, core_wdata, core_rdata;
   logic core_req, core_write, core_spec, cs_port16, core_ack, core_err;
   logic [1:0] core_size;
   logic [31:0] ext_addr, ext_wdata, ext_rdata, rv, r, d, lm;
   logic core_beat_done, core_beat_err, core_spec_blocked, ext_start;
   logic ext_data_oe_n, ext_ta_n, tea_n, irq, fail_next, re, e, blk;
   logic [0:3] stb;
   logic [3:0] lag;
   logic [15:0] m16;
   logic [3:0] sq[$];
   logic aq[$];
   logic [15:0] wq[$];
   int err_count, samples_checked, cyc, nberr, nbd;
   logic [1:0] t_sz [7] = '{2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
   logic [1:0] t_off [7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
   logic [3:0] t_s0 [7] = '{4'h0, 4'h5, 4'h9, 4'h7, 4'hB, 4'h1, 4'h3};
   logic [31:0] g_msk [9] = '{32'h0, 32'h0, 32'hFC00, 32'hFC00,
      32'hFC00, 32'hF800, 32'hF800, 32'h8000, 32'h8000};
   logic [31:0] g_adr [9] = '{32'h123457FC, 32'h12345800, 32'h1234D400,
      32'h12355400, 32'h92345400, 32'h12345C00, 32'h12345000,
      32'h1234D400, 32'h12341400};
   logic [8:0] g_exp = 9'h0A5;

   ebisg_top i_ebisg_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_req(core_req), .core_addr(core_addr), .core_size(core_size),
      .core_write(core_write), .core_wdata(core_wdata),
      .core_spec(core_spec), .cs_port16(cs_port16), .core_ack(core_ack),
      .core_err(core_err), .core_rdata(core_rdata),
      .core_beat_done(core_beat_done), .core_beat_err(core_beat_err),
      .core_spec_blocked(core_spec_blocked), .ext_start(ext_start),
      .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .ext_data_oe_n(ext_data_oe_n), .ext_rdata(ext_rdata),
      .byte_lane_strobes(stb), .ext_ta_n(ext_ta_n),
      .transfer_error_ack_n(tea_n), .irq(irq));

   ebisg_slave i_ebisg_slave (.pclk(pclk), .presetn(presetn),
      .ext_start(ext_start), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .ext_data_oe_n(ext_data_oe_n), .byte_lane_strobes(stb), .lag(lag),
      .fail_next(fail_next), .ext_rdata(ext_rdata), .ext_ta_n(ext_ta_n),
      .transfer_error_ack_n(tea_n));

   task close_out();
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task apb(input logic w, input logic [31:0] a, input logic [31:0] dd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_count++;
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task core_op(input logic [1:0] sz, input logic [31:0] a, input logic w,
      input logic [31:0] dd, input logic sp, input logic p16);
      int n;
      n = 0;
      sq.delete();
      aq.delete();
      wq.delete();
      nberr = 0;
      nbd = 0;
      blk = 1'b0;
      @(posedge pclk);
      core_req <= 1'b1;
      core_size <= sz;
      core_addr <= a;
      core_write <= w;
      core_wdata <= dd;
      core_spec <= sp;
      cs_port16 <= p16;
      if (sp) begin
         repeat (8) @(posedge pclk);
         blk = core_spec_blocked;
         check(32'(sq.size() == 0), 32'(blk));
         core_spec <= 1'b0;
      end
      do begin
         @(posedge pclk);
         n++;
      end while (core_ack !== 1'b1 && n < 300);
      if (n >= 300) err_count++;
      r = core_rdata;
      e = core_err;
      core_req <= 1'b0;
   endtask : core_op

   always @(posedge pclk) begin
      if (ext_start === 1'b1) begin
         sq.push_back(stb);
         aq.push_back(ext_addr[1]);
         wq.push_back(ext_wdata[31:16]);
      end
      if (core_beat_err === 1'b1) nberr++;
      if (core_beat_done === 1'b1) nbd++;
   end

   // Ceiling well above the fewer than a thousand cycles the tests need
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, core_req, core_write} = '0;
      {core_spec, cs_port16, fail_next, lag, core_size} = '0;
      {core_addr, core_wdata} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `EBISG_GUARD_BASE_OFS, 32'h0);
      check(rv, 32'h0);
      apb(1'b0, `EBISG_GUARD_MASK_OFS, 32'h0);
      check(rv, 32'h0);
      apb(1'b1, `EBISG_GUARD_BASE_OFS, 32'hFFFFFFFF);
      apb(1'b0, `EBISG_GUARD_BASE_OFS, 32'h0);
      check(rv, 32'hFFFFFC00);
      apb(1'b1, `EBISG_GUARD_MASK_OFS, 32'hFFFFFFFF);
      apb(1'b0, `EBISG_GUARD_MASK_OFS, 32'h0);
      check(rv, 32'h0000FC00);
      apb(1'b0, 32'h8007FC38, 32'h0);
      check(32'(re), 32'h1);
      check(rv, 32'h0);
      apb(1'b0, `EBISG_STATE_OFS, 32'h0);
      check(rv, 32'h1);
      apb(1'b1, `EBISG_GUARD_BASE_OFS, 32'h12345400);
      for (int i = 0; i < 9; i++) begin
         apb(1'b1, `EBISG_GUARD_MASK_OFS, g_msk[i]);
         core_op(2'h0, g_adr[i], 1'b0, 32'h0, 1'b1, 1'b1);
         check(32'(blk), 32'(g_exp[i]));
      end
      core_op(2'h0, 32'h12345400, 1'b1, 32'h0, 1'b1, 1'b1);
      check(32'(blk), 32'h0);
      check(32'(irq), 32'h0);
      apb(1'b0, `EBISG_IRQ_STATUS_OFS, 32'h0);
      check(rv, 32'h1);
      apb(1'b0, `EBISG_IRQ_STATUS_OFS, 32'h0);
      check(rv, 32'h0);
      apb(1'b1, `EBISG_IRQ_MASK_OFS, 32'h3);
      apb(1'b0, `EBISG_IRQ_MASK_OFS, 32'h0);
      check(rv, 32'h3);
      core_op(2'h0, 32'h12345400, 1'b0, 32'h0, 1'b1, 1'b1);
      check(32'(irq), 32'h1);
      apb(1'b0, `EBISG_IRQ_STATUS_OFS, 32'h0);
      check(rv, 32'h1);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0);
      // A held load that the core withdraws must never reach the pins
      sq.delete();
      @(posedge pclk);
      core_req <= 1'b1;
      core_spec <= 1'b1;
      core_write <= 1'b0;
      core_addr <= 32'h12345400;
      repeat (4) @(posedge pclk);
      check(32'(core_spec_blocked), 32'h1);
      core_req <= 1'b0;
      repeat (20) @(posedge pclk);
      check(32'(sq.size()), 32'h0);
      check(32'(core_spec_blocked), 32'h0);
      apb(1'b0, `EBISG_IRQ_STATUS_OFS, 32'h0);
      check(rv, 32'h1);
      lag <= 4'h7;
      for (int i = 0; i < 7; i++) begin
         d = 32'hA1B2C3D4 ^ (32'h11111111 * i);
         lm = (t_sz[i] == 2'h2) ? 32'hFFFFFFFF : ((t_sz[i] == 2'h1) ?
            32'hFFFF0000 : 32'hFF000000) >> (8 * t_off[i]);
         m16 = (t_sz[i] != 2'h0) ? 16'hFFFF :
            (t_off[i][0] ? 16'h00FF : 16'hFF00);
         for (int k = 1; k >= 0; k--) begin
            core_op(t_sz[i], 32'h100 + t_off[i], k[0], d, 1'b0, 1'b1);
            check(32'(sq.size()), (t_sz[i] == 2'h2) ? 32'h2 : 32'h1);
            check(32'(nbd), (t_sz[i] == 2'h2) ? 32'h2 : 32'h1);
            check(32'(sq[0]), 32'(t_s0[i]));
            check(32'(aq[0]), 32'(t_off[i][1]));
            check(32'(e), 32'h0);
            if (k == 1)
               check(32'(wq[0] & m16),
                  32'((t_off[i][1] ? d[15:0] : d[31:16]) & m16));
            else
               check(r & lm, d & lm);
            if (t_sz[i] == 2'h2) begin
               check(32'(sq[1]), 32'h2);
               check(32'(aq[1]), 32'h1);
               if (k == 1) check(32'(wq[1]), 32'(d[15:0]));
            end
         end
      end
      lag <= 4'h0;
      core_op(2'h2, 32'h180, 1'b1, 32'h01020304, 1'b0, 1'b0);
      check(32'(sq.size()), 32'h1);
      check(32'(sq[0]), 32'h0);
      core_op(2'h0, 32'h182, 1'b0, 32'h0, 1'b0, 1'b0);
      check(32'(sq[0]), 32'hD);
      fail_next <= 1'b1;
      core_op(2'h2, 32'h200, 1'b0, 32'h0, 1'b0, 1'b1);
      fail_next <= 1'b0;
      repeat (2) @(posedge pclk);
      check(32'(sq.size()), 32'h2);
      check(32'(nberr), 32'h2);
      check(32'(e), 32'h1);
      check(32'(irq), 32'h1);
      apb(1'b0, `EBISG_IRQ_STATUS_OFS, 32'h0);
      check(rv, 32'h2);
      close_out();
   end
endmodule : tb
